// >>> bench/adc_result_trigger_regs_tb.sv
`timescale 1ns/1ns
`include "adc_regs.svh"

// Compare one value against its expectation and count it
`define CHK(got, exp) begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("BAD t=%0t got %h exp %h", $time, got, exp); \
    end \
end

module adc_result_trigger_regs_tb;
    import adc_regs_pkg::*;

    typedef struct {
        logic       align;
        logic [9:0] res;
        logic [7:0] lo;
        logic [7:0] hi;
    } row_t;

    logic        ref_clk;
    logic        rst;
    logic        ce;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        conv_done;
    logic [9:0]  conv_result;
    logic        conv_start;
    logic        conv_enable;
    logic [3:0]  channel_select_bits;
    logic [6:0]  trig_flags;
    logic        comp_neg_from_mux;
    logic [7:0]  digital_input_disable_0;
    logic [7:0]  port_pins;
    logic [7:0]  port_pins_masked;
    logic [31:0] d;
    int          errors;
    int          n_tests;
    int          starts;
    int          ex;
    row_t        rows [5] = '{
        '{1'b0, 10'h270, 8'h70, 8'h02},
        '{1'b1, 10'h270, 8'h00, 8'h9C},
        '{1'b0, 10'h3FF, 8'hFF, 8'h03},
        '{1'b1, 10'h3FF, 8'hC0, 8'hFF},
        '{1'b1, 10'h001, 8'h40, 8'h00}
    };

    adc_result_trigger_regs dut (
        .ref_clk                 (ref_clk),
        .rst                     (rst),
        .ce                      (ce),
        .hsel                    (hsel),
        .haddr                   (haddr),
        .htrans                  (htrans),
        .hwrite                  (hwrite),
        .hsize                   (hsize),
        .hwdata                  (hwdata),
        .hready                  (hreadyout),
        .hreadyout               (hreadyout),
        .hresp                   (hresp),
        .hrdata                  (hrdata),
        .conv_done               (conv_done),
        .conv_result             (conv_result),
        .conv_start              (conv_start),
        .conv_enable             (conv_enable),
        .channel_select_bits     (channel_select_bits),
        .trig_flags              (trig_flags),
        .comp_neg_from_mux       (comp_neg_from_mux),
        .digital_input_disable_0 (digital_input_disable_0),
        .port_pins               (port_pins),
        .port_pins_masked        (port_pins_masked)
    );

    ////////////////////////////////////////////////////////////////////
    // Clock and start pulse counter
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (conv_start === 1'b1) begin
            starts <= starts + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Verdict and hang guard
    task automatic wrap_up;
        if (errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (100000) @(posedge ref_clk);
        errors++;
        wrap_up;
    end

    ////////////////////////////////////////////////////////////////////
    // Bus master: wait for hready, one transfer, helpers
    task automatic bus_wait;
        int i;
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (hreadyout !== 1'b1 && i < 50);
        if (hreadyout !== 1'b1) begin
            errors++;
            wrap_up;
        end
    endtask : bus_wait

    task automatic bus(input logic [7:0] idx, input logic wr_en,
                       input logic [31:0] wd, output logic [31:0] rd_v);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr_en;
        haddr  <= {22'h000000, idx, 2'b00};
        bus_wait;
        htrans <= 2'b00;
        hwdata <= wd;
        bus_wait;
        rd_v = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        logic [31:0] dummy;
        bus(idx, 1'b1, {24'h000000, v}, dummy);
    endtask : wr

    task automatic rd(input logic [7:0] idx, output logic [31:0] v);
        bus(idx, 1'b0, 32'h00000000, v);
    endtask : rd

    // Converter finishing with a result
    task automatic conv(input logic [9:0] r);
        conv_result <= r;
        conv_done   <= 1'b1;
        @(posedge ref_clk);
        conv_done   <= 1'b0;
        @(posedge ref_clk);
    endtask : conv

    task automatic settle;
        repeat (4) @(posedge ref_clk);
    endtask : settle

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        conv_done = 1'b0;
        conv_result = 10'h000;
        trig_flags = 7'h00;
        port_pins = 8'h00;
        errors = 0;
        n_tests = 0;
        starts = 0;
        ex = 0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        // Reset values and an unmapped place
        rd(`IDX_RESULT_LOW, d);
        `CHK(d, 32'h00000000);
        rd(`IDX_RESULT_HIGH, d);
        `CHK(d, 32'h00000000);
        rd(`IDX_CONTROL_B, d);
        `CHK(d, 32'h00000000);
        rd(`IDX_INPUT_DISABLE, d);
        `CHK(d, 32'h00000000);
        wr(8'h10, 8'hFF);
        rd(8'h10, d);
        `CHK(d, 32'h00000000);
        `CHK(hresp, 1'b0);
        // Alignment table
        wr(`IDX_CONTROL_A, 8'h80);
        foreach (rows[k]) begin
            wr(`IDX_MUX_SELECT, {2'b00, rows[k].align, 5'h00});
            conv(rows[k].res);
            rd(`IDX_RESULT_LOW, d);
            `CHK(d, {24'h000000, rows[k].lo});
            rd(`IDX_RESULT_HIGH, d);
            `CHK(d, {24'h000000, rows[k].hi});
            rd(`IDX_CONTROL_A, d);
            `CHK(d[4], 1'b1);
            wr(`IDX_CONTROL_A, 8'h90);
        end
        // Lock between low and high reads, read-only result
        wr(`IDX_MUX_SELECT, 8'h07);
        conv(10'h155);
        `CHK(channel_select_bits, 4'h7);
        rd(`IDX_RESULT_LOW, d);
        `CHK(d, 32'h00000055);
        conv(10'h2AA);
        rd(`IDX_RESULT_HIGH, d);
        `CHK(d, 32'h00000001);
        conv(10'h2AA);
        wr(`IDX_RESULT_LOW, 8'hFF);
        rd(`IDX_RESULT_LOW, d);
        `CHK(d, 32'h000000AA);
        rd(`IDX_RESULT_HIGH, d);
        `CHK(d, 32'h00000002);
        // Completion while clock enable is low is not seen
        ce <= 1'b0;
        conv(10'h111);
        ce <= 1'b1;
        rd(`IDX_RESULT_LOW, d);
        `CHK(d, 32'h000000AA);
        rd(`IDX_RESULT_HIGH, d);
        `CHK(d, 32'h00000002);
        // Digital input disable and port view
        port_pins <= 8'hFF;
        wr(`IDX_INPUT_DISABLE, 8'hA5);
        settle;
        `CHK(digital_input_disable_0, 8'hA5);
        `CHK(port_pins_masked, 8'h5A);
        rd(`IDX_PORT_VIEW, d);
        `CHK(d, 32'h0000005A);
        // Comparator negative input routing
        wr(`IDX_CONTROL_A, 8'h10);
        wr(`IDX_CONTROL_B, 8'h40);
        settle;
        `CHK(comp_neg_from_mux, 1'b1);
        wr(`IDX_CONTROL_A, 8'h80);
        settle;
        `CHK(comp_neg_from_mux, 1'b0);
        wr(`IDX_CONTROL_A, 8'h00);
        wr(`IDX_CONTROL_B, 8'h00);
        settle;
        `CHK(comp_neg_from_mux, 1'b0);
        // Source ignored while auto-trigger is off
        wr(`IDX_CONTROL_A, 8'h90);
        wr(`IDX_CONTROL_B, 8'h01);
        trig_flags <= 7'h01;
        settle;
        `CHK(starts, ex);
        // Source codes 1 to 7 each fire on their own rising flag
        wr(`IDX_CONTROL_A, 8'hB0);
        for (int k = 1; k < 8; k++) begin
            trig_flags <= 7'h00;
            wr(`IDX_CONTROL_B, 8'(k));
            settle;
            trig_flags <= 7'(1 << (k - 1));
            settle;
            ex++;
            `CHK(starts, ex);
            conv(10'h000);
        end
        // Switching from a clear source to a set one
        trig_flags <= 7'h02;
        wr(`IDX_CONTROL_B, 8'h01);
        settle;
        `CHK(starts, ex);
        wr(`IDX_CONTROL_B, 8'h02);
        settle;
        ex++;
        `CHK(starts, ex);
        conv(10'h000);
        // Free running entered from a clear source, completion flag set
        trig_flags <= 7'h00;
        wr(`IDX_CONTROL_B, 8'h00);
        settle;
        `CHK(starts, ex);
        // Manual start, then enable off
        wr(`IDX_CONTROL_A, 8'hC0);
        settle;
        ex++;
        `CHK(starts, ex);
        `CHK(conv_enable, 1'b1);
        conv(10'h000);
        wr(`IDX_CONTROL_A, 8'h40);
        settle;
        `CHK(conv_enable, 1'b0);
        `CHK(starts, ex);
        wrap_up;
    end
endmodule : adc_result_trigger_regs_tb

// >>> logic/adc_regs.svh
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH

////////////////////////////////////////////////////////////////////////
// Register indices; byte address is four times the index
`define IDX_RESULT_LOW    8'h78
`define IDX_RESULT_HIGH   8'h79
`define IDX_CONTROL_A     8'h7A
`define IDX_CONTROL_B     8'h7B
`define IDX_MUX_SELECT    8'h7C
`define IDX_INPUT_DISABLE 8'h7E
`define IDX_PORT_VIEW     8'h7F
`define IDX_NONE          8'h00

////////////////////////////////////////////////////////////////////////
// Field positions
`define CA_ENABLE_BIT     7
`define CA_START_BIT      6
`define CA_AUTO_BIT       5
`define CA_FLAG_BIT       4
`define CB_MUX_EN_BIT     6
`define CB_SRC_MSB        2
`define MS_ALIGN_BIT      5
`define MS_CHAN_MSB       3

////////////////////////////////////////////////////////////////////////
// Reset values and the zero upper-address compare value
`define RST_BYTE          8'h00
`define RST_RESULT        10'h000
`define RST_CHAN          4'h0
`define RST_WORD          32'h00000000
`define UPPER_ADDR_ZERO   22'h000000

`endif

// >>> logic/adc_regs_pkg.sv
package adc_regs_pkg;

    // Auto-trigger source codes
    typedef enum logic [2:0] {
        src_free_run    = 3'b000,
        src_comparator  = 3'b001,
        src_ext_int0    = 3'b010,
        src_t0_cmp_a    = 3'b011,
        src_t0_ovf      = 3'b100,
        src_t1_cmp_b    = 3'b101,
        src_t1_ovf      = 3'b110,
        src_t1_capture  = 3'b111
    } trig_src_t;

    // Bus slave phases
    typedef enum logic [1:0] {
        ph_idle      = 2'b00,
        ph_write     = 2'b01,
        ph_read_wait = 2'b10,
        ph_read_done = 2'b11
    } bus_phase_t;

    typedef struct packed {
        trig_src_t prev_sel;
        logic      prev_flag;
    } trig_state_t;

    typedef struct packed {
        bus_phase_t  phase;
        logic [7:0]  idx;
        logic [9:0]  result;
        logic        lock;
        logic        conv_en;
        logic        auto_en;
        logic        cc_flag;
        logic        busy;
        logic        start;
        logic        left_align;
        logic [3:0]  chan;
        logic        cmp_mux_en;
        trig_src_t   src_sel;
        logic [7:0]  didr;
        logic [7:0]  pin_view;
        logic [31:0] hrdata;
    } regs_state_t;

endpackage : adc_regs_pkg

// >>> logic/adc_result_trigger_regs.sv
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
`include "adc_regs.svh"

// What this block does and what software must do
// R01: Result low byte at base, high at base+1
// R02: Finished conversion loads the result pair
// R03: Low byte read locks result until high read
// R04: Software reads low byte before high byte
// R05: Alignment clear gives right-aligned result
// R06: Alignment set gives left-aligned result
// R07: Mux enable, converter off: mux feeds comparator
// R08: Mux enable clear: dedicated pin feeds comparator
// R09: Trigger source ignored without auto-trigger
// R10: Rising edge of chosen flag starts conversion
// R11: Source switch clear-to-set counts as edge
// R12: Switching to free running never triggers
// R13: Eight trigger source codes decoded
// R14: Disable bit turns off pin input buffer
// R15: Disabled pin reads zero in port view
// R16: Software disables buffers of analog pins
// R17: Completion flag set when conversion finishes
// R18: Auto-trigger only while its enable is one
// R19: Enable bit switches converter on and off
// R20: Writes to result bytes change nothing
module adc_result_trigger_regs
    import adc_regs_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        conv_done,
    input  wire logic [9:0]  conv_result,
    output logic             conv_start,
    output logic             conv_enable,
    output logic [3:0]       channel_select_bits,
    input  wire logic [6:0]  trig_flags,
    output logic             comp_neg_from_mux,
    output logic [7:0]       digital_input_disable_0,
    input  wire logic [7:0]  port_pins,
    output logic [7:0]       port_pins_masked
);

    regs_state_t q;
    regs_state_t d;
    logic        accept;
    logic        addr_ok;
    logic [7:0]  wd;

    trig_if tif ();

    ////////////////////////////////////////////////////////////////////
    // Result placement in the 16-bit pair
    function automatic logic [15:0] align_result(
        input logic [9:0] res,
        input logic       left
    );
        if (left) begin
            align_result = {res, 6'h00}; // R06
        end else begin
            align_result = {6'h00, res}; // R05
        end
    endfunction : align_result

    // Read value of one register
    function automatic logic [7:0] read_byte(
        input logic [7:0]  idx,
        input regs_state_t s
    );
        logic [15:0] pair;
        pair = align_result(s.result, s.left_align);
        case (idx)
            `IDX_RESULT_LOW:    read_byte = pair[7:0]; // R01
            `IDX_RESULT_HIGH:   read_byte = pair[15:8]; // R01
            `IDX_CONTROL_A:     read_byte = {s.conv_en, s.busy,
                                             s.auto_en, s.cc_flag,
                                             4'h0};
            `IDX_CONTROL_B:     read_byte = {1'b0, s.cmp_mux_en, 3'h0,
                                             s.src_sel};
            `IDX_MUX_SELECT:    read_byte = {2'h0, s.left_align, 1'b0,
                                             s.chan};
            `IDX_INPUT_DISABLE: read_byte = s.didr;
            `IDX_PORT_VIEW:     read_byte = s.pin_view;
            default:            read_byte = `RST_BYTE;
        endcase
    endfunction : read_byte

    ////////////////////////////////////////////////////////////////////
    // Trigger unit hookup
    assign tif.src_sel   = q.src_sel;
    assign tif.auto_en   = q.auto_en;
    assign tif.conv_en   = q.conv_en;
    assign tif.cc_flag   = q.cc_flag;
    assign tif.ext_flags = trig_flags;

    trigger_unit u_trig (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ce      (ce),
        .tif     (tif)
    );

    ////////////////////////////////////////////////////////////////////
    // Address phase decode
    assign accept  = hsel && htrans[1] && hready;
    assign addr_ok = (haddr[31:10] == `UPPER_ADDR_ZERO) &&
                     (haddr[1:0] == 2'h0);
    assign wd      = hwdata[7:0];

    // Next-state logic
    always_comb begin
        logic sw_start;
        logic req;
        sw_start = 1'b0;
        req      = 1'b0;
        d        = q;
        d.start  = 1'b0;

        // Bus phase sequencing; reads insert one wait state
        case (q.phase)
            ph_read_wait: begin
                d.phase  = ph_read_done;
                d.hrdata = {24'h000000, read_byte(q.idx, q)};
                if (q.idx == `IDX_RESULT_LOW) begin
                    d.lock = 1'b1; // R03
                end
                if (q.idx == `IDX_RESULT_HIGH) begin
                    d.lock = 1'b0; // R03
                end
            end
            default: begin
                if (accept) begin
                    d.phase = hwrite ? ph_write : ph_read_wait;
                    d.idx   = addr_ok ? haddr[9:2] : `IDX_NONE;
                end else begin
                    d.phase = ph_idle;
                end
            end
        endcase

        // Write commit in the data phase
        if (q.phase == ph_write) begin
            case (q.idx)
                `IDX_CONTROL_A: begin
                    d.conv_en = wd[`CA_ENABLE_BIT]; // R19
                    d.auto_en = wd[`CA_AUTO_BIT]; // R18
                    sw_start  = wd[`CA_START_BIT];
                    if (wd[`CA_FLAG_BIT]) begin
                        d.cc_flag = 1'b0;
                    end
                end
                `IDX_CONTROL_B: begin
                    d.cmp_mux_en = wd[`CB_MUX_EN_BIT];
                    d.src_sel    = trig_src_t'(wd[`CB_SRC_MSB:0]);
                end
                `IDX_MUX_SELECT: begin
                    d.left_align = wd[`MS_ALIGN_BIT];
                    d.chan       = wd[`MS_CHAN_MSB:0];
                end
                `IDX_INPUT_DISABLE: begin
                    d.didr = wd;
                end
                default: begin
                    // Result bytes and unmapped: no effect
                end // R20
            endcase
        end

        // Conversion completion; set beats software clear
        if (conv_done && q.conv_en) begin
            d.busy    = 1'b0;
            d.cc_flag = 1'b1; // R17
            if (!q.lock) begin
                d.result = conv_result; // R02
            end
        end

        // Start by software or by trigger edge
        req = (sw_start || tif.fire) && !q.busy; // R10 R11
        if (req && d.conv_en) begin
            d.start = 1'b1;
            d.busy  = 1'b1;
        end

        // Disabling ends any conversion in flight
        if (!d.conv_en) begin
            d.busy  = 1'b0; // R19
            d.start = 1'b0;
        end

        // Port view masks disabled pins
        d.pin_view = port_pins & ~d.didr; // R15
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q <= '{phase: ph_idle, idx: `IDX_NONE,
                   result: `RST_RESULT, lock: 1'b0, conv_en: 1'b0,
                   auto_en: 1'b0, cc_flag: 1'b0, busy: 1'b0,
                   start: 1'b0, left_align: 1'b0, chan: `RST_CHAN,
                   cmp_mux_en: 1'b0, src_sel: src_free_run,
                   didr: `RST_BYTE, pin_view: `RST_BYTE,
                   hrdata: `RST_WORD};
        end else if (ce) begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign hreadyout               = (q.phase != ph_read_wait);
    assign hresp                   = 1'b0;
    assign hrdata                  = q.hrdata;
    assign conv_start              = q.start;
    assign conv_enable             = q.conv_en;
    assign channel_select_bits     = q.chan;
    assign comp_neg_from_mux       = q.cmp_mux_en && !q.conv_en; // R07 R08
    assign digital_input_disable_0 = q.didr; // R14
    assign port_pins_masked        = q.pin_view;

    ////////////////////////////////////////////////////////////////////
    property p_right_low;
        @(posedge ref_clk) disable iff (rst)
        (ce && q.phase == ph_read_wait && q.idx == `IDX_RESULT_LOW &&
         !q.left_align) |=> hrdata == {24'h000000, $past(q.result[7:0])};
    endproperty
    a_right_low: assert property (p_right_low) // R05
        else $error("right aligned low byte wrong");

    property p_right_high;
        @(posedge ref_clk) disable iff (rst)
        (ce && q.phase == ph_read_wait && q.idx == `IDX_RESULT_HIGH &&
         !q.left_align)
        |=> hrdata == {30'h00000000, $past(q.result[9:8])};
    endproperty
    a_right_high: assert property (p_right_high) // R01
        else $error("right aligned high byte wrong");

    property p_left_high;
        @(posedge ref_clk) disable iff (rst)
        (ce && q.phase == ph_read_wait && q.idx == `IDX_RESULT_HIGH &&
         q.left_align) |=> hrdata == {24'h000000, $past(q.result[9:2])};
    endproperty
    a_left_high: assert property (p_left_high) // R06
        else $error("left aligned high byte wrong");

    property p_load;
        @(posedge ref_clk) disable iff (rst)
        (ce && conv_done && q.conv_en && !q.lock)
        |=> q.result == $past(conv_result);
    endproperty
    a_load: assert property (p_load) // R02
        else $error("result not loaded on completion");

    property p_locked;
        @(posedge ref_clk) disable iff (rst)
        (ce && q.phase == ph_read_wait && q.idx == `IDX_RESULT_LOW)
        ##1 (q.lock && !(q.phase == ph_read_wait &&
                         q.idx == `IDX_RESULT_HIGH)) [*2]
        |=> $stable(q.result);
    endproperty
    a_locked: assert property (p_locked) // R03
        else $error("result changed while locked");

    property p_flag;
        @(posedge ref_clk) disable iff (rst)
        (ce && conv_done && q.conv_en) |=> q.cc_flag;
    endproperty
    a_flag: assert property (p_flag) // R17
        else $error("completion flag not set");

    property p_disable;
        @(posedge ref_clk) disable iff (rst)
        (ce && q.phase == ph_write && q.idx == `IDX_CONTROL_A &&
         !hwdata[`CA_ENABLE_BIT]) |=> !q.conv_en && !q.busy && !conv_start;
    endproperty
    a_disable: assert property (p_disable) // R19
        else $error("converter still on after disable");

    property p_comp_mux;
        @(posedge ref_clk) disable iff (rst)
        q.conv_en |-> !comp_neg_from_mux;
    endproperty
    a_comp_mux: assert property (p_comp_mux) // R07
        else $error("mux fed comparator while converter on");

    property p_pin_mask;
        @(posedge ref_clk) disable iff (rst)
        $past(ce) |-> (port_pins_masked & digital_input_disable_0) == 8'h00;
    endproperty
    a_pin_mask: assert property (p_pin_mask) // R15
        else $error("disabled pin reads one");

    property p_ro_result;
        @(posedge ref_clk) disable iff (rst)
        (ce && q.phase == ph_write && !conv_done &&
         (q.idx == `IDX_RESULT_LOW || q.idx == `IDX_RESULT_HIGH))
        |=> $stable(q.result);
    endproperty
    a_ro_result: assert property (p_ro_result) // R20
        else $error("write changed result");

endmodule : adc_result_trigger_regs

// >>> logic/trig_if.sv
`timescale 1ns/1ns
interface trig_if;
    import adc_regs_pkg::*;
    trig_src_t  src_sel;
    logic       auto_en;
    logic       conv_en;
    logic       cc_flag;
    logic [6:0] ext_flags;
    logic       fire;
    modport ctrl (output src_sel, output auto_en, output conv_en,
                  output cc_flag, output ext_flags, input fire);
    modport unit (input src_sel, input auto_en, input conv_en,
                  input cc_flag, input ext_flags, output fire);
endinterface : trig_if

// >>> logic/trigger_unit.sv
`timescale 1ns/1ns
module trigger_unit
    import adc_regs_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic ce,
    trig_if.unit      tif
);

    trig_state_t q;
    trig_state_t d;
    logic [7:0]  flags;
    logic        cur;
    logic        to_free;

    ////////////////////////////////////////////////////////////////////
    // Source decode: code 0 watches the completion flag
    assign flags   = {tif.ext_flags, tif.cc_flag};
    assign cur     = flags[tif.src_sel]; // R13
    assign to_free = (tif.src_sel == src_free_run) &&
                     (q.prev_sel != src_free_run);

    // Rising edge of selected flag, gated by auto and enable
    assign tif.fire = tif.auto_en && tif.conv_en && cur &&
                      !q.prev_flag && !to_free; // R09 R10 R11 R12 R18

    // Edge history
    always_comb begin
        d           = q;
        d.prev_flag = cur;
        d.prev_sel  = tif.src_sel;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q <= '{prev_sel: src_free_run, prev_flag: 1'b0};
        end else if (ce) begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    property p_no_auto;
        @(posedge ref_clk) disable iff (rst)
        !tif.auto_en |-> !tif.fire;
    endproperty
    a_no_auto: assert property (p_no_auto) // R09
        else $error("trigger fired with auto-trigger off");

    property p_edge_fires;
        @(posedge ref_clk) disable iff (rst)
        (ce && $past(ce) && tif.auto_en && tif.conv_en &&
         $stable(tif.src_sel) && $rose(cur)) |-> tif.fire;
    endproperty
    a_edge_fires: assert property (p_edge_fires) // R10
        else $error("rising source edge did not fire");

    property p_free_switch;
        @(posedge ref_clk) disable iff (rst)
        (tif.src_sel == src_free_run &&
         $past(tif.src_sel) != src_free_run && $past(ce))
        |-> !tif.fire;
    endproperty
    a_free_switch: assert property (p_free_switch) // R12
        else $error("switch to free running made a trigger");

endmodule : trigger_unit
